// ===== hdl/spc_buf.sv
// Two-entry first-in first-out receive buffer, head word held in a flop.
// Assumes the filler honours in_ready and the drainer honours out_valid.
`timescale 1ns/100ps
module spc_buf
  import spc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Stream
  spc_buf_if.store bus
);
  logic [SPC_DATA_W-1:0] head;
  logic [SPC_DATA_W-1:0] tail;
  logic [1:0] count;
  logic push;
  logic pop;

  assign bus.in_ready = (count != 2'h2);
  assign bus.out_valid = (count != 2'h0);
  assign bus.out_data = head;
  assign push = bus.in_valid && bus.in_ready;
  assign pop = bus.out_valid && bus.out_ready;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      count <= 2'h0;
    end else if (push && !pop) begin
      count <= count + 2'h1;
    end else if (pop && !push) begin
      count <= count - 2'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      head <= SPC_DATA_RST;
      tail <= SPC_DATA_RST;
    end else begin
      if (pop) begin
        head <= (count == 2'h2) ? tail : bus.in_data;
      end else if (push && count == 2'h0) begin
        head <= bus.in_data;
      end
      if (push && (count == 2'h2 || (count == 2'h1 && !pop))) begin
        tail <= bus.in_data;
      end
    end
  end

  a_buf_no_over: assert property (@(posedge clk_sys) disable iff (!rstn)
    (count == 2'h2 && !pop) |=> count == 2'h2) // [R6]
    else $error("receive buffer count changed while full");
endmodule

// ===== hdl/spc_buf_if.sv
// Valid/ready carrier between the core and its receive buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface spc_buf_if;
  import spc_pkg::*;
  logic in_valid;
  logic in_ready;
  logic [SPC_DATA_W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [SPC_DATA_W-1:0] out_data;
  modport user (output in_valid, output in_data, output out_ready,
                input in_ready, input out_valid, input out_data);
  modport store (input in_valid, input in_data, input out_ready,
                 output in_ready, output out_valid, output out_data);
endinterface

// ===== hdl/spc_core.sv
// Serial peripheral core: master/slave byte exchange over one shift register.
// Assumes pin inputs are synchronous to clk_sys; slave SCK phases are at
// least three system clocks long. Mode 0 timing: SCK idles low, data
// sampled on the rising edge and shifted on the falling edge.
`timescale 1ns/100ps
module spc_core
  import spc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Configuration
  input wire logic enable,
  input wire logic master_mode,
  input wire logic [1:0] presc,
  input wire logic clk2x,
  input wire logic lsb_first,
  input wire logic buf_mode,
  // User pin directions and master select level
  input wire logic mosi_dir,
  input wire logic miso_dir,
  input wire logic sck_dir,
  input wire logic ss_dir,
  input wire logic ss_level_n,
  // Software data access
  input wire logic wr_strobe,
  input wire logic [SPC_DATA_W-1:0] wr_data,
  input wire logic rd_strobe,
  output logic [SPC_DATA_W-1:0] rd_data,
  // Status
  output logic busy,
  output logic xfer_done,
  input wire logic xfer_done_clr,
  output logic wcol,
  input wire logic wcol_clr,
  output logic done_pulse,
  output logic rx_avail,
  // Pins
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic ss_n_in,
  output logic ss_n_out,
  output logic ss_n_oe
);
  spc_state_t state;
  logic [SPC_DATA_W-1:0] shreg;
  logic [SPC_DATA_W-1:0] rx_data;
  logic [SPC_DATA_W-1:0] tx_buf;
  logic [SPC_DATA_W-1:0] done_byte;
  logic tx_full;
  logic [SPC_CNT_W-1:0] half;
  logic [SPC_CNT_W-1:0] div_cnt;
  logic [2:0] bit_cnt;
  logic samp;
  logic sck_s1, sck_s2, sck_s3;
  logic ss_s1, ss_s2;
  logic mosi_s1, mosi_s2;
  logic slv_run;
  logic tick, m_rise, m_fall, s_rise, s_fall;
  logic sample_now, shift_now, in_bit, out_bit;
  logic start, tx_load, is_master, is_slave;
  spc_buf_if rxq ();

  ////////////////////////////////////////////////////////////////////////
  // Mode and bit rate

  assign is_master = enable && master_mode; // [R1]
  assign is_slave = enable && !master_mode; // [R1]

  // Four prescaler codes, halved by double speed, give seven rates
  always_comb begin
    case (presc) // [R9]
      SPC_PRESC_DIV4: half = SPC_HALF_DIV4;
      SPC_PRESC_DIV16: half = SPC_HALF_DIV16;
      SPC_PRESC_DIV64: half = SPC_HALF_DIV64;
      default: half = SPC_HALF_DIV128;
    endcase
    if (clk2x) begin
      half = half >> 1; // [R10]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Slave input synchronisers

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_s3 <= 1'b0;
      ss_s1 <= 1'b1;
      ss_s2 <= 1'b1;
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
    end else begin
      sck_s1 <= sck_in; // [R8]
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      ss_s1 <= ss_n_in;
      ss_s2 <= ss_s1;
      mosi_s1 <= mosi_in;
      mosi_s2 <= mosi_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Edge events

  assign tick = (div_cnt == '0);
  assign m_rise = is_master && state == SPC_RUN && tick && !sck_out; // [R7]
  assign m_fall = is_master && state == SPC_RUN && tick && sck_out; // [R7]
  assign s_rise = is_slave && !ss_s2 && sck_s2 && !sck_s3; // [R2] [R8]
  assign s_fall = is_slave && !ss_s2 && slv_run && !sck_s2 && sck_s3; // [R8]
  assign sample_now = m_rise || s_rise;
  assign shift_now = m_fall || s_fall;
  assign in_bit = master_mode ? miso_in : mosi_s2; // [R3]
  assign out_bit = lsb_first ? shreg[0] : shreg[SPC_DATA_W-1]; // [R11]
  assign done_byte = lsb_first ? {samp, shreg[SPC_DATA_W-1:1]}
                               : {shreg[SPC_DATA_W-2:0], samp}; // [R11]
  assign done_pulse = shift_now && bit_cnt == SPC_LAST_BIT; // [R14]
  assign busy = master_mode ? (state == SPC_RUN) : slv_run;

  // In buffer mode the master waits for receive room so no word is lost
  assign start = is_master && state == SPC_IDLE
    && (buf_mode ? (tx_full && rxq.in_ready) : wr_strobe); // [R17]
  assign tx_load = buf_mode && tx_full
    && (is_master ? start : (is_slave && !slv_run));

  ////////////////////////////////////////////////////////////////////////
  // Master sequencer and clock generator

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state <= SPC_IDLE;
    end else if (!is_master) begin
      state <= SPC_IDLE;
    end else begin
      case (state)
        SPC_IDLE: if (start) state <= SPC_RUN;
        SPC_RUN: if (done_pulse) state <= SPC_IDLE;
        default: state <= SPC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      div_cnt <= '0;
      sck_out <= 1'b0;
    end else if (state != SPC_RUN || !is_master) begin
      div_cnt <= half - 7'h01;
      sck_out <= 1'b0; // [R20]
    end else if (tick) begin
      div_cnt <= half - 7'h01;
      sck_out <= !sck_out && !done_pulse; // [R20]
    end else begin
      div_cnt <= div_cnt - 7'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Slave framing

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      slv_run <= 1'b0;
    end else if (!is_slave || ss_s2) begin
      slv_run <= 1'b0; // [R2]
    end else if (s_rise) begin
      slv_run <= 1'b1;
    end else if (done_pulse) begin
      slv_run <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shift register and bit counter

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      samp <= 1'b0;
      bit_cnt <= 3'h0;
    end else begin
      if (sample_now) begin
        samp <= in_bit; // [R4]
      end
      if (start || (is_slave && ss_s2) || !enable) begin
        bit_cnt <= 3'h0;
      end else if (shift_now) begin
        bit_cnt <= bit_cnt + 3'h1; // [R20]
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      shreg <= SPC_DATA_RST;
    end else if (shift_now) begin
      shreg <= done_byte; // [R4]
    end else if (wr_strobe && !buf_mode) begin
      shreg <= wr_data; // [R5] [R19]
    end else if (tx_load) begin
      shreg <= tx_buf; // [R5]
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tx_buf <= SPC_DATA_RST;
      tx_full <= 1'b0;
    end else if (!buf_mode) begin
      tx_full <= 1'b0;
    end else if (wr_strobe && (!tx_full || tx_load)) begin
      tx_buf <= wr_data; // [R5]
      tx_full <= 1'b1;
    end else if (tx_load) begin
      tx_full <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive path

  assign rxq.in_valid = done_pulse && buf_mode;
  assign rxq.in_data = done_byte;
  assign rxq.out_ready = rd_strobe && buf_mode;
  assign rx_avail = buf_mode ? rxq.out_valid : xfer_done;

  spc_buf u_rxq (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .bus(rxq)
  );

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rx_data <= SPC_DATA_RST;
    end else if (done_pulse) begin
      rx_data <= done_byte; // [R21]
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rd_data <= SPC_DATA_RST;
    end else if (rd_strobe) begin
      rd_data <= buf_mode ? rxq.out_data : rx_data; // [R6]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Flags: a setting event wins over a clear in the same cycle

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      xfer_done <= 1'b0;
    end else if (done_pulse) begin
      xfer_done <= 1'b1; // [R12]
    end else if (xfer_done_clr) begin
      xfer_done <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wcol <= 1'b0;
    end else if (wr_strobe && busy && (!buf_mode || tx_full)) begin
      wcol <= 1'b1; // [R13] [R19]
    end else if (wcol_clr) begin
      wcol <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin directions and drive

  always_comb begin
    mosi_out = out_bit; // [R3]
    miso_out = out_bit; // [R3]
    ss_n_out = ss_level_n; // [R2]
    mosi_oe = 1'b0;
    miso_oe = 1'b0;
    sck_oe = 1'b0;
    ss_n_oe = 1'b0;
    if (is_master) begin
      mosi_oe = mosi_dir; // [R15] [R16]
      sck_oe = sck_dir;
      ss_n_oe = ss_dir;
    end else if (is_slave) begin
      miso_oe = miso_dir && !ss_n_in; // [R15] [R18]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  logic [3:0] rise_cnt;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rise_cnt <= 4'h0;
    end else if (start) begin
      rise_cnt <= 4'h0;
    end else if (m_rise) begin
      rise_cnt <= rise_cnt + 4'h1;
    end
  end

  a_miso_in_master: assert property (@(posedge clk_sys) disable iff (!rstn)
    is_master |-> !miso_oe) // [R15]
    else $error("MISO driven in master mode");
  a_slave_pins_in: assert property (@(posedge clk_sys) disable iff (!rstn)
    is_slave |-> !mosi_oe && !sck_oe && !ss_n_oe) // [R15]
    else $error("slave drives an input pin");
  a_miso_ss_gate: assert property (@(posedge clk_sys) disable iff (!rstn)
    ss_n_in |-> !miso_oe) // [R18]
    else $error("MISO driven while deselected");
  a_done_sets_flag: assert property (@(posedge clk_sys) disable iff (!rstn)
    done_pulse |=> xfer_done) // [R12]
    else $error("completion flag not set");
  a_rx_copy_byte: assert property (@(posedge clk_sys) disable iff (!rstn)
    done_pulse |=> rx_data == $past(done_byte)) // [R21]
    else $error("receive register not loaded at completion");
  a_wcol_on_busy: assert property (@(posedge clk_sys) disable iff (!rstn)
    (wr_strobe && busy && !buf_mode) |=> wcol) // [R13]
    else $error("collision not flagged");
  a_sck_idle_low: assert property (@(posedge clk_sys) disable iff (!rstn)
    (is_master && !busy) |=> !sck_out || busy) // [R20]
    else $error("SCK not idle low");
  a_eight_clocks: assert property (@(posedge clk_sys) disable iff (!rstn)
    (done_pulse && is_master) |-> rise_cnt == 4'h8) // [R20]
    else $error("master transfer not eight SCK cycles");
  a_write_loads: assert property (@(posedge clk_sys) disable iff (!rstn)
    (wr_strobe && !buf_mode && !shift_now) |=> shreg == $past(wr_data)) // [R5]
    else $error("write did not load shift register");
  a_start_runs: assert property (@(posedge clk_sys) disable iff (!rstn)
    (start && !buf_mode) |=> busy ##1 busy) // [R17]
    else $error("master write did not start transfer");

  c_master_done: cover property (@(posedge clk_sys) disable iff (!rstn)
    done_pulse && is_master);
  c_slave_done: cover property (@(posedge clk_sys) disable iff (!rstn)
    done_pulse && is_slave);
  c_buf_full: cover property (@(posedge clk_sys) disable iff (!rstn)
    buf_mode && !rxq.in_ready);
  c_collision: cover property (@(posedge clk_sys) disable iff (!rstn)
    $rose(wcol));
endmodule

// ===== hdl/spc_pkg.sv
// Constants shared by the serial peripheral core and its receive buffer.
// Assumes a single 10 MHz system clock and synchronous pin inputs.
//
// Contract
// R1: Core configurable as master or slave
// R2: Master asserts active-low select; slave needs it
// R3: MOSI master-to-slave, MISO slave-to-master, master clocks
// R4: One 8-bit shift register, full duplex
// R5: Write loads shifter, or transmit buffer
// R6: Read returns receive register, or receive buffer
// R7: Master derives SCK from system clock
// R8: Slave synchronises SCK, edges drive shifting
// R9: Seven selectable master bit rates
// R10: Double speed gives SCK at clock/2
// R11: LSB-first or MSB-first, both directions
// R12: Completion sets end-of-transfer flag
// R13: Write during transfer sets collision flag; in buffer mode the code sets it only while the transmit buffer is full
// R14: Completion event available while CPU idles
// R15: Pin directions forced by master/slave mode
// R16: Three-wire full duplex, select optional
// R17: Master write starts new transfer
// R18: Slave drives MISO only while selected
// R19: Normal-mode early write corrupts, flags collision
// R20: Exactly eight SCK cycles, idle low between
// R21: Received byte copied when flag sets
package spc_pkg;
  localparam int SPC_DATA_W = 8;
  localparam int SPC_CNT_W = 7;
  localparam int SPC_BUF_DEPTH = 2;
  // Half SCK periods in system clocks, per prescaler code
  localparam logic [6:0] SPC_HALF_DIV4 = 7'h02;
  localparam logic [6:0] SPC_HALF_DIV16 = 7'h08;
  localparam logic [6:0] SPC_HALF_DIV64 = 7'h20;
  localparam logic [6:0] SPC_HALF_DIV128 = 7'h40;
  localparam logic [1:0] SPC_PRESC_DIV4 = 2'h0;
  localparam logic [1:0] SPC_PRESC_DIV16 = 2'h1;
  localparam logic [1:0] SPC_PRESC_DIV64 = 2'h2;
  localparam logic [2:0] SPC_LAST_BIT = 3'h7;
  localparam logic [7:0] SPC_DATA_RST = 8'h00;
  typedef enum logic {SPC_IDLE, SPC_RUN} spc_state_t;
endpackage

// ===== sim/spc_slave_model.sv
// Behavioural SPI slave in mode 0 facing the core when it is master.
// Assumes SCK idles low and the select line is active low.
`timescale 1ns/100ps
module spc_slave_model (
  // Link
  input wire logic sck,
  input wire logic mosi,
  input wire logic ss_n,
  output logic miso,
  // Control and observation
  input wire logic lsb_first,
  input wire logic [7:0] tx_byte,
  output logic [7:0] rx_byte,
  output int rises
);
  logic [7:0] sh = 8'h00;
  logic bit_out = 1'b0;
  initial rx_byte = 8'h00;
  initial rises = 0;
  // Deselected line shows the inverse of the last bit
  assign miso = ss_n ? ~bit_out : bit_out;
  always @(negedge ss_n) begin
    sh = tx_byte;
    bit_out = lsb_first ? tx_byte[0] : tx_byte[7];
    rises = 0;
  end
  always @(posedge sck) begin
    if (!ss_n) begin
      rx_byte = lsb_first ? {mosi, rx_byte[7:1]} : {rx_byte[6:0], mosi};
      rises = rises + 1;
    end
  end
  // Echoes the byte just received as the next reply
  always @(negedge sck) begin
    if (!ss_n) begin
      sh = (rises % 8 == 0) ? rx_byte : (lsb_first ? sh >> 1 : sh << 1);
      bit_out = lsb_first ? sh[0] : sh[7];
    end
  end
endmodule

// ===== sim/test_spi_master_slave_core.sv
// Self-checking bench for the serial peripheral core.
// Assumes the receive buffer sits inside spc_core; a slave model answers.
`timescale 1ns/100ps
module test_spi_master_slave_core;
  import spc_pkg::*;
  logic clk_sys, rstn, enable, master_mode, clk2x, lsb_first, buf_mode;
  logic [1:0] presc;
  logic mosi_dir, miso_dir, sck_dir, ss_dir, ss_level_n, wr_strobe, rd_strobe;
  logic xfer_done_clr, wcol_clr, tb_sck, tb_mosi, tb_ss_n;
  logic [7:0] wr_data, rd_data, m_tx, m_rx;
  logic busy, xfer_done, wcol, done_pulse, rx_avail, m_miso;
  logic sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, ss_n_out, ss_n_oe;
  int fail_count, samples_checked, cycles, m_rises;
  time t_prev, t_last;
  wire sck_in = sck_oe ? sck_out : tb_sck;
  wire mosi_in = mosi_oe ? mosi_out : tb_mosi;
  wire ss_n_in = ss_n_oe ? ss_n_out : tb_ss_n;
  wire miso_in = miso_oe ? miso_out : m_miso;
  spc_core spc_core_inst (.clk_sys, .rstn, .enable, .master_mode, .presc, .clk2x,
    .lsb_first, .buf_mode, .mosi_dir, .miso_dir, .sck_dir, .ss_dir, .ss_level_n,
    .wr_strobe, .wr_data, .rd_strobe, .rd_data, .busy, .xfer_done, .xfer_done_clr,
    .wcol, .wcol_clr, .done_pulse, .rx_avail, .sck_in, .sck_out, .sck_oe, .mosi_in,
    .mosi_out, .mosi_oe, .miso_in, .miso_out, .miso_oe, .ss_n_in, .ss_n_out, .ss_n_oe);
  spc_slave_model spc_slave_model_inst (.sck(sck_in), .mosi(mosi_in), .ss_n(ss_n_in),
    .miso(m_miso), .lsb_first, .tx_byte(m_tx), .rx_byte(m_rx), .rises(m_rises));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge sck_out) begin
    t_prev = t_last;
    t_last = $time;
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic setup(input logic mm, lsb, x2, bm, input logic [1:0] p);
    @(posedge clk_sys);
    {master_mode, lsb_first, clk2x, buf_mode, presc} <= {mm, lsb, x2, bm, p};
    {ss_level_n, xfer_done_clr, wcol_clr} <= 3'h7;
    @(posedge clk_sys);
    {ss_level_n, xfer_done_clr, wcol_clr} <= 3'h0;
    @(negedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] d);
    @(posedge clk_sys);
    wr_strobe <= 1'b1;
    wr_data <= d;
    @(posedge clk_sys);
    wr_strobe <= 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] exp);
    @(posedge clk_sys);
    rd_strobe <= 1'b1;
    @(posedge clk_sys);
    rd_strobe <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    check("rd_data", rd_data, exp);
  endtask
  task automatic wait_done;
    int i;
    for (i = 0; i < 3000; i++) begin
      @(negedge clk_sys);
      if (done_pulse === 1'b1) break;
    end
    check("done_pulse", 16'(i < 3000), 16'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_basic;
    m_tx = 8'h3C;
    setup(1'b1, 1'b0, 1'b0, 1'b0, 2'h0);
    wr(8'hA5);
    check("busy", busy, 16'h1);
    check("ss_n_out", ss_n_out, 16'h0);
    check("oe", {miso_oe, mosi_oe, sck_oe, ss_n_oe}, 16'h7);
    wait_done;
    check("rises", 16'(m_rises), 16'h8);
    check("slave_rx", m_rx, 16'hA5);
    @(negedge clk_sys);
    check("sck_idle", sck_out, 16'h0);
    check("xfer_done", xfer_done, 16'h1);
    rd(8'h3C);
    setup(1'b1, 1'b0, 1'b0, 1'b0, 2'h0);
    check("xfer_done_clr", xfer_done, 16'h0);
    @(posedge clk_sys);
    enable <= 1'b0;
    @(negedge clk_sys);
    check("oe_off", {miso_oe, mosi_oe, sck_oe, ss_n_oe}, 16'h0);
    @(posedge clk_sys);
    enable <= 1'b1;
    @(negedge clk_sys);
    $display("test basic done");
  endtask
  task automatic test_rates;
    for (int k = 0; k < 7; k++) begin
      m_tx = 8'hB2;
      setup(1'b1, k[0], (k < 6) && !k[0], 1'b0, (k == 6) ? 2'h3 : 2'(k >> 1));
      wr(8'(8'h1D ^ k));
      wait_done;
      check("period", 16'((t_last - t_prev) / 100), 16'(2 << k));
      check("slave_rx", m_rx, 16'(8'h1D ^ k));
      rd(8'hB2);
    end
    $display("test rates done");
  endtask
  task automatic test_collision;
    setup(1'b1, 1'b0, 1'b0, 1'b0, 2'h0);
    wr(8'hF0);
    repeat (3) @(posedge clk_sys);
    wr(8'h0F);
    check("wcol", wcol, 16'h1);
    wait_done;
    setup(1'b1, 1'b0, 1'b0, 1'b0, 2'h0);
    check("wcol_clr", wcol, 16'h0);
    $display("test collision done");
  endtask
  task automatic test_buffer;
    m_tx = 8'h96;
    setup(1'b1, 1'b0, 1'b0, 1'b1, 2'h0);
    wr(8'h11);
    wr(8'h22);
    repeat (4) @(posedge clk_sys);
    wr(8'h33);
    check("wcol", wcol, 16'h1);
    wait_done;
    wait_done;
    wr(8'h44);
    repeat (100) @(negedge clk_sys);
    check("stall", 16'(m_rises), 16'h10);
    check("rx_avail", rx_avail, 16'h1);
    rd(8'h96);
    wait_done;
    check("slave_rx", m_rx, 16'h44);
    rd(8'h11);
    rd(8'h22);
    check("rx_empty", rx_avail, 16'h0);
    $display("test buffer done");
  endtask
  task automatic test_slave;
    setup(1'b0, 1'b0, 1'b0, 1'b0, 2'h0);
    wr(8'hC3);
    check("miso_oe", miso_oe, 16'h0);
    check("oe", {mosi_oe, sck_oe, ss_n_oe}, 16'h0);
    @(posedge clk_sys);
    tb_ss_n <= 1'b0;
    repeat (4) @(negedge clk_sys);
    check("miso_oe", miso_oe, 16'h1);
    for (int b = 7; b >= 0; b--) begin
      @(posedge clk_sys);
      tb_mosi <= 1'(8'h5A >> b);
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      check("miso_bit", miso_in, 16'(8'hC3 >> b & 1));
      @(posedge clk_sys);
      tb_sck <= 1'b1;
      repeat (4) @(posedge clk_sys);
      tb_sck <= 1'b0;
    end
    repeat (8) @(negedge clk_sys);
    check("xfer_done", xfer_done, 16'h1);
    rd(8'h5A);
    @(posedge clk_sys);
    tb_ss_n <= 1'b1;
    @(negedge clk_sys);
    check("miso_oe", miso_oe, 16'h0);
    $display("test slave done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    {rstn, master_mode, clk2x, lsb_first, buf_mode, presc} = 7'h00;
    {enable, mosi_dir, miso_dir, sck_dir, ss_dir, ss_level_n, tb_ss_n} = 7'h7F;
    {wr_strobe, rd_strobe, xfer_done_clr, wcol_clr, tb_sck, tb_mosi} = 6'h00;
    {wr_data, m_tx} = 16'h0000;
    {fail_count, samples_checked, cycles} = 0;
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    test_basic;
    test_rates;
    test_collision;
    test_buffer;
    test_slave;
    end_of_test;
  end
endmodule
